// ---- src/cmrm_consts.svh ----
// Purpose: Constants for the core memory request multiplexer.
// Assumes: 10 MHz system clock.
// Notes: Cycle length is counted in clock periods.
`ifndef CMRM_CONSTS_SVH
`define CMRM_CONSTS_SVH
`define CMRM_NUM_CH 4
`define CMRM_ADDR_W 15
`define CMRM_DATA_W 24
`define CMRM_SEL_BIT 14
`define CMRM_CLK_NS 100
`define CMRM_CYCLE_NS 1700
`define CMRM_CYCLE_CLKS (`CMRM_CYCLE_NS / `CMRM_CLK_NS)
`define CMRM_INIT_CLKS 1
`define CMRM_READY_AT 10
`define CMRM_CNT_W 5
`endif

// ---- src/cmrm_mux.sv ----
// Purpose: Fixed priority request multiplexer in front of the core memory.
// Assumes: Requests held until release; module timing runs on its own.
// Notes: Channel 0 is bulk controller, 3 is the processor.
//
// Operation
// RULE_01 - Grant starts cycle and hands memory control
// RULE_02 - Timing starts only on requester request
// RULE_03 - Send initiate pulse and mode signal
// RULE_04 - Route address; write data in, read out
// RULE_05 - First clock sets pending, clears enable
// RULE_06 - Processor grant only with no others pending
// RULE_07 - Processor address through address multiplexer
// RULE_08 - Processor data through data multiplexer
// RULE_09 - Processor store select sets module mode
// RULE_10 - Parity check enabled only on reads
// RULE_11 - Ready and release only to granted
// RULE_12 - Store gives write request, else read
// RULE_13 - Write request clear/write, otherwise read/restore
// RULE_14 - Fixed priority, bulk highest, processor lowest
// RULE_15 - No preemption; re-arbitrate at cycle end
// RULE_16 - Address bit 14 selects memory module
// RULE_17 - Check read data odd parity, flag errors
// RULE_18 - Reset clears pending flops and grants
`default_nettype none
`include "cmrm_consts.svh"
module cmrm_mux (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire cmrm_pkg::cmrm_req_t [`CMRM_NUM_CH-1:0] chan_in,
   input wire logic [`CMRM_DATA_W-1:0] mem_rdata_in,
   input wire logic mem_rparity_in,
   input wire logic mem_ready_in,
   input wire logic mem_release_in,
   output logic [`CMRM_NUM_CH-1:0] grant_out,
   output logic [`CMRM_NUM_CH-1:0] data_ready_out,
   output logic [`CMRM_NUM_CH-1:0] mem_release_out,
   output logic [`CMRM_DATA_W-1:0] rdata_out,
   output logic [`CMRM_ADDR_W-1:0] addr_mux_out,
   output logic [`CMRM_DATA_W-1:0] data_mux_out,
   output logic write_request_out,
   output logic read_request_out,
   output logic module1_select_out,
   output logic module2_select_out,
   output logic parity_error_out,
   output logic busy_out
);
   import cmrm_pkg::*;

   // ****************************************************************
   // Arbitration
   // ****************************************************************
   cmrm_state_t state_q, state_d;
   logic [`CMRM_NUM_CH-1:0] pending_q;
   logic [`CMRM_NUM_CH-1:0] grant_q;
   logic time_count_enable_ff;
   logic [`CMRM_CNT_W-1:0] count_q;
   logic [`CMRM_NUM_CH-1:0] req_vec;
   logic [`CMRM_NUM_CH-1:0] prio_grant;
   logic [1:0] win_idx;

   genvar g;
   for (g = 0; g < `CMRM_NUM_CH; g++) begin : g_req
      assign req_vec[g] = chan_in[g].req;
   end

   // Pending flops take requests only while the memory is idle.
   wire take_req = (state_q == CMRM_IDLE) && (|req_vec); // RULE_02
   wire proc_pending_ff = pending_q[3];
   wire bulk_pending_ff = pending_q[0];

   // Priority gates; a lower channel wins only if all higher are clear.
   assign prio_grant[0] = bulk_pending_ff; // RULE_14
   assign prio_grant[1] = pending_q[1] & ~pending_q[0];
   assign prio_grant[2] = pending_q[2] & ~|pending_q[1:0];
   assign prio_grant[3] = proc_pending_ff & ~|pending_q[2:0]; // RULE_06
   assign win_idx = prio_grant[0] ? 2'd0 : prio_grant[1] ? 2'd1 :
                    prio_grant[2] ? 2'd2 : 2'd3;

   wire cycle_end = (state_q == CMRM_RUN) &&
                    (count_q == `CMRM_CNT_W'(`CMRM_CYCLE_CLKS - 1));

   // Sequencer: idle, grant one cycle, run for the fixed cycle length.
   always_comb begin
      state_d = state_q;
      case (state_q)
         CMRM_IDLE: begin
            if (|req_vec) state_d = CMRM_GRANT;
         end
         CMRM_GRANT: state_d = CMRM_RUN; // RULE_01
         CMRM_RUN: begin
            if (cycle_end) state_d = CMRM_IDLE; // RULE_15
         end
         default: state_d = CMRM_IDLE;
      endcase
   end

   // Grant is frozen for the whole cycle, so no preemption is possible.
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         state_q <= CMRM_IDLE; // RULE_18
         pending_q <= '0;
         grant_q <= '0;
         time_count_enable_ff <= 1'b1;
         count_q <= '0;
      end else begin
         state_q <= state_d;
         if (take_req) begin
            pending_q <= req_vec; // RULE_05
            time_count_enable_ff <= 1'b0;
         end else if (cycle_end) begin
            pending_q <= '0;
            time_count_enable_ff <= 1'b1;
         end
         if (state_q == CMRM_GRANT) grant_q <= prio_grant; // RULE_15
         else if (cycle_end) grant_q <= '0;
         count_q <= (state_q == CMRM_RUN) ?
                    count_q + `CMRM_CNT_W'(1) : '0;
      end
   end

   // ****************************************************************
   // Datapath multiplexers
   // ****************************************************************
   cmrm_req_t win;
   assign win = chan_in[win_idx]; // RULE_04
   wire in_cycle = (state_q == CMRM_RUN);
   wire is_write = win.store; // RULE_12
   wire init_pulse = in_cycle && (count_q == '0); // RULE_03
   wire [`CMRM_NUM_CH-1:0] rd_strobe =
      (mem_ready_in && in_cycle && !is_write) ? grant_q : '0;

   logic [`CMRM_ADDR_W-1:0] addr_q;
   logic [`CMRM_DATA_W-1:0] data_q, rdata_q;
   logic wr_q, rd_q, m1_q, m2_q, busy_q;
   logic [`CMRM_NUM_CH-1:0] ready_q, rel_q;

   // Outputs registered; addr and data follow the frozen winner.
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         addr_q <= '0;
         data_q <= '0;
         rdata_q <= '0;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         m1_q <= 1'b0;
         m2_q <= 1'b0;
         busy_q <= 1'b0;
         ready_q <= '0;
         rel_q <= '0;
      end else begin
         addr_q <= state_q == CMRM_IDLE ? '0 : win.addr; // RULE_07
         data_q <= state_q == CMRM_IDLE ? '0 : win.wdata; // RULE_08
         wr_q <= in_cycle && is_write; // RULE_09 RULE_13
         rd_q <= in_cycle && !is_write; // RULE_13
         m1_q <= init_pulse && !win.addr[`CMRM_SEL_BIT]; // RULE_16
         m2_q <= init_pulse && win.addr[`CMRM_SEL_BIT]; // RULE_03
         busy_q <= state_d != CMRM_IDLE;
         ready_q <= mem_ready_in && in_cycle ? grant_q : '0; // RULE_11
         rel_q <= mem_release_in && in_cycle ? grant_q : '0; // RULE_11
         if (|rd_strobe) rdata_q <= mem_rdata_in; // RULE_04
      end
   end

   // Parity checker is enabled on read strobes only.
   cmrm_parity cmrm_parity_i (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .enable_in(|rd_strobe), // RULE_10
      .data_in(mem_rdata_in),
      .parity_in(mem_rparity_in),
      .error_out(parity_error_out)
   );

   assign grant_out = grant_q;
   assign data_ready_out = ready_q;
   assign mem_release_out = rel_q;
   assign rdata_out = rdata_q;
   assign addr_mux_out = addr_q;
   assign data_mux_out = data_q;
   assign write_request_out = wr_q;
   assign read_request_out = rd_q;
   assign module1_select_out = m1_q;
   assign module2_select_out = m2_q;
   assign busy_out = busy_q;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   // Grants are exclusive and the processor wins only when alone.
   one_grant_a: assert property (@(posedge clk_in) // RULE_14
      disable iff (!reset_n_in) $onehot0(grant_q))
      else $error("more than one grant");
   proc_grant_a: assert property (@(posedge clk_in) // RULE_06
      disable iff (!reset_n_in) grant_q[3] |-> !(|pending_q[2:0]))
      else $error("processor granted over another channel");
   // A grant phase must always hand the memory to one requester.
   grant_start_a: assert property (@(posedge clk_in) // RULE_01
      disable iff (!reset_n_in) (state_q == CMRM_GRANT) |=>
      (grant_q != '0) && in_cycle)
      else $error("grant phase without a running cycle");
   no_preempt_a: assert property (@(posedge clk_in) // RULE_15
      disable iff (!reset_n_in) (in_cycle && !cycle_end) |=> $stable(grant_q))
      else $error("grant changed mid cycle");
   pend_take_a: assert property (@(posedge clk_in) // RULE_05
      disable iff (!reset_n_in) take_req |=> (pending_q == $past(req_vec))
      && !time_count_enable_ff) else $error("pending not set");
   start_req_a: assert property (@(posedge clk_in) // RULE_02
      disable iff (!reset_n_in) (state_q == CMRM_IDLE && !(|req_vec))
      |=> state_q == CMRM_IDLE) else $error("cycle without request");
   // A longer initiate would start the module a second time.
   init_once_a: assert property (@(posedge clk_in) // RULE_03
      disable iff (!reset_n_in) (m1_q || m2_q) |=> !(m1_q || m2_q))
      else $error("initiate pulse longer than one clock");
   init_sel_a: assert property (@(posedge clk_in) // RULE_16
      disable iff (!reset_n_in) init_pulse |=>
      (m2_q == $past(win.addr[`CMRM_SEL_BIT])) && (m1_q != m2_q))
      else $error("wrong module select");
   mode_excl_a: assert property (@(posedge clk_in) // RULE_13
      disable iff (!reset_n_in) !(wr_q && rd_q))
      else $error("read and write together");
   ready_route_a: assert property (@(posedge clk_in) // RULE_11
      disable iff (!reset_n_in) (ready_q & ~$past(grant_q)) == '0)
      else $error("ready to ungranted");
endmodule
`default_nettype wire

// ---- src/cmrm_parity.sv ----
// Purpose: Odd parity check of one read word with its parity bit.
// Assumes: Inputs synchronous to clk_in.
// Notes: Flag is registered and only updates while enabled.
`default_nettype none
`include "cmrm_consts.svh"
module cmrm_parity (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic enable_in,
   input wire logic [`CMRM_DATA_W-1:0] data_in,
   input wire logic parity_in,
   output logic error_out
);
   logic error_q;
   wire odd_ok = ^{data_in, parity_in};
   // Error is raised only on an enabled strobe whose word has even parity.
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         error_q <= 1'b0;
      end else if (enable_in) begin
         error_q <= ~odd_ok; // RULE_17
      end
   end
   assign error_out = error_q;
endmodule
`default_nettype wire

// ---- src/cmrm_pkg.sv ----
// Purpose: Types for the core memory request multiplexer.
// Assumes: Nothing beyond the constants header.
// Notes: One struct carries one requester's memory request.
`default_nettype none
`include "cmrm_consts.svh"
package cmrm_pkg;
   typedef struct packed {
      logic req;
      logic store;
      logic [`CMRM_ADDR_W-1:0] addr;
      logic [`CMRM_DATA_W-1:0] wdata;
   } cmrm_req_t;
   typedef enum logic [2:0] {
      CMRM_IDLE = 3'b001,
      CMRM_GRANT = 3'b010,
      CMRM_RUN = 3'b100
   } cmrm_state_t;
endpackage
`default_nettype wire

// ---- verif/cmrm_mem_model.sv ----
// Purpose: Core memory module model answering each initiate pulse.
// Assumes: One memory cycle at a time, started by a select pulse.
// Notes: bad_parity_in spoils the parity bit of the read word.
`default_nettype none
`include "cmrm_consts.svh"
module cmrm_mem_model (
   input wire logic clk_in,
   input wire logic start_in,
   input wire logic bad_parity_in,
   output logic [`CMRM_DATA_W-1:0] rdata_out,
   output logic parity_out,
   output logic ready_out,
   output logic release_out
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   // Module timing runs on its own once initiated.
   always @(posedge clk_in) begin
      cnt <= start_in ? 1 : (cnt != 0 && cnt < 12) ? cnt + 1 : 0;
   end
   // Data is only valid at the strobe; a wrong word shows otherwise.
   assign ready_out = (cnt == 8);
   assign release_out = (cnt == 12);
   assign rdata_out = ready_out ? 24'hA5C3E1 : 24'h5A3C1E;
   assign parity_out = ~^rdata_out ^ bad_parity_in;
endmodule
`default_nettype wire

// ---- verif/cmrm_mux_bench.sv ----
// Purpose: Self-checking bench for the request multiplexer.
// Assumes: The memory model answers every initiate pulse.
// Notes: Requests are held until their grant drops.
`default_nettype none
`include "cmrm_consts.svh"
module cmrm_mux_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import cmrm_pkg::*;
   logic clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic bad_par = 1'b0;
   cmrm_req_t [3:0] chan = '0;
   logic [3:0] grant, ready, rel;
   logic [23:0] rdata, dmux, m_data;
   logic [14:0] amux;
   logic wr, rd, sel1, sel2, perr, busy, m_par, m_rdy, m_rel;
   int n_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   always #50 clk_in = ~clk_in;
   cmrm_mux cmrm_mux_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .chan_in(chan), .mem_rdata_in(m_data), .mem_rparity_in(m_par),
      .mem_ready_in(m_rdy), .mem_release_in(m_rel), .grant_out(grant),
      .data_ready_out(ready), .mem_release_out(rel), .rdata_out(rdata),
      .addr_mux_out(amux), .data_mux_out(dmux), .write_request_out(wr),
      .read_request_out(rd), .module1_select_out(sel1),
      .module2_select_out(sel2), .parity_error_out(perr),
      .busy_out(busy));
   cmrm_mem_model cmrm_mem_model_i (.clk_in(clk_in),
      .start_in(sel1 | sel2), .bad_parity_in(bad_par),
      .rdata_out(m_data), .parity_out(m_par), .ready_out(m_rdy),
      .release_out(m_rel));
   task automatic results();
      $display("errors %0d checks %0d", n_errors, total_checks);
      if (n_errors == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // A hang would stall the run, so it is cut short as a failure.
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         n_errors++;
         results();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %h not %h", $time, seen, exp);
      end
   endtask
   // Inputs move and outputs are read 1 ns after each rising edge.
   task automatic tick();
      @(posedge clk_in);
      #1;
   endtask
   task automatic put(input int ch, input logic st, input logic [14:0] a,
                      input logic [23:0] d);
      chan[ch] = '{1'b1, st, a, d};
   endtask
   // Follows one channel through a whole cycle, phase by phase.
   task automatic serve(input int ch);
      logic [3:0] oh;
      logic st;
      int n;
      oh = 4'h1 << ch;
      st = chan[ch].store;
      for (n = 0; n < 80 && grant !== oh; n++)
         tick();
      check(grant, oh);
      check(busy, 1'b1);
      for (n = 0; n < 4 && sel1 !== 1'b1 && sel2 !== 1'b1; n++)
         tick();
      check({sel2, sel1}, chan[ch].addr[14] ? 2'h2 : 2'h1);
      check(amux, chan[ch].addr);
      check({wr, rd}, st ? 2'h2 : 2'h1);
      if (st)
         check(dmux, chan[ch].wdata);
      for (n = 0; n < 20 && ready === 4'h0; n++)
         tick();
      check(ready, oh);
      if (!st)
         check(rdata, 24'hA5C3E1);
      tick();
      if (!st)
         check(perr, bad_par);
      for (n = 0; n < 20 && rel === 4'h0; n++)
         tick();
      check({rel, grant}, {oh, oh});
      for (n = 0; n < 20 && grant !== 4'h0; n++)
         tick();
      chan[ch].req = 1'b0;
      // One edge with the request low before any new request is raised.
      tick();
   endtask
   task automatic t_read();
      put(3, 1'b0, 15'h0123, 24'h000000);
      serve(3);
   endtask
   task automatic t_write();
      put(3, 1'b1, 15'h4ABC, 24'h123456);
      serve(3);
   endtask
   // Three channels at once must be served strictly by rank.
   task automatic t_prio();
      put(0, 1'b1, 15'h4001, 24'hFEDCBA);
      put(2, 1'b0, 15'h0002, 24'h000000);
      put(3, 1'b1, 15'h0003, 24'h00000F);
      serve(0);
      serve(2);
      serve(3);
   endtask
   // A bulk request arriving mid-cycle waits for the running one.
   task automatic t_hold();
      int n;
      put(3, 1'b0, 15'h7FFF, 24'h000000);
      for (n = 0; n < 10 && grant !== 4'h8; n++)
         tick();
      put(0, 1'b0, 15'h0000, 24'h000000);
      serve(3);
      serve(0);
   endtask
   // A write with a spoiled parity bit must leave the flag alone.
   task automatic t_parity();
      bad_par = 1'b1;
      put(3, 1'b1, 15'h0555, 24'h00ABCD);
      serve(3);
      check(perr, 1'b0);
      put(3, 1'b0, 15'h0777, 24'h000000);
      serve(3);
      bad_par = 1'b0;
   endtask
   initial begin
      repeat (20)
         tick();
      check({grant, busy}, 5'h00);
      reset_n_in = 1'b1;
      t_read();
      t_write();
      t_prio();
      t_hold();
      t_parity();
      results();
   end
endmodule
`default_nettype wire
